// [core/scl_cfg.svh]
// constants of the smbus configuration loader
`ifndef SCL_CFG_SVH
`define SCL_CFG_SVH
`define SCL_CLK_NS 50
`define SCL_QTR_NS 2500
`define SCL_QTR_CYC ((`SCL_QTR_NS + `SCL_CLK_NS - 1) / `SCL_CLK_NS)
`define SCL_ADDR7_BASE 7'h18
`define SCL_TEST_STRAP 4'h0
`define SCL_EE_WR 8'ha0
`define SCL_EE_WORD 8'h00
`define SCL_EE_RD 8'ha1
`define SCL_CFG_BYTES 16
`define SCL_POR_WAIT 2'h3
`endif

// [core/scl_link.sv]
// byte receiver clocked by the smbus serial clock line
`default_nettype none
module scl_link
  import scl_pkg::*;
(
  // link clock and reset
  input wire logic link_clk_i,
  input wire logic nrst_i,
  input wire logic link_clr_i,
  // serial data as seen on the pin
  input wire logic sda_i,
  // byte handed to the core clock domain
  output logic [7:0] byte_o,
  output logic ack_o,
  output logic first_o
);
  scl_link_t s, n;
  logic rst_n;

  // a start clears the counter asynchronously: the clock stands still between frames
  assign rst_n = nrst_i & ~link_clr_i;

  // count eight data bits, then flag the ninth (acknowledge) clock
  always_comb
  begin
    n = s;
    if (s.cnt == 4'h8)
    begin
      n.cnt = 4'h0;
      n.first = 1'b0;
      n.ack = 1'b0;
    end
    else
    begin
      n.sh = {s.sh[6:0], sda_i};
      n.cnt = s.cnt + 4'h1;
      n.ack = (s.cnt == 4'h7);
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      s <= '{cnt: 4'h0, sh: 8'h00, first: 1'b1, ack: 1'b0};
    else
      s <= n;
  end

  assign byte_o = s.sh;
  assign ack_o = s.ack;
  assign first_o = s.first;

  ack_slot_a: assert property (@(posedge link_clk_i) disable iff (!rst_n)
    (s.cnt == 4'h7) |=> s.ack && s.cnt == 4'h8)
    else $error("acknowledge slot not after eight bits");
endmodule // scl_link
`default_nettype wire

// [core/scl_loader.sv]
// power-up configuration loader and smbus slave front end
// Contract
// - mode pin sampled at power-up: floating is master load, high is slave
// - master mode fetches configuration from serial eeprom as bus master
// - fetch starts only once load request is low; bus untouched before
// - load done driven low when the fetch has finished
// - after the fetch the bus is released and the device is a slave
// - address straps captured once at power-up as inputs
// - after capture strap pins drive per-channel lock, high when locked
// - write address is 0x30 plus twice strap, seven-bit 0x18 plus strap
// - address byte is 8 bits, lsb is direction, upper seven address
// - slave mode with request not low uses write address 0x30
// - registers read and written over smbus after address capture
// - data and clock lines only pulled low, else released
`default_nettype none
`include "scl_cfg.svh"
module scl_loader
  import scl_pkg::*;
#(
  parameter int CFG_BYTES = `SCL_CFG_BYTES
)
(
  // clocks and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic serial_clock_line_i,
  // smbus pins, open drain
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic serial_clock_line_o,
  output logic serial_clock_line_oe_n_o,
  // power-up straps and chain pins
  input wire logic config_mode_select_i,
  input wire logic load_req_n_i,
  output logic load_done_n_o,
  // shared strap and lock pins
  input wire logic [3:0] addr_strap_i,
  output logic [3:0] lock_o,
  output logic [3:0] lock_oe_n_o,
  input wire logic [3:0] chan_locked_i,
  // register file port
  output logic reg_wr_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);
  localparam logic [7:0] QTR_LAST = 8'(`SCL_QTR_CYC - 1);
  localparam logic [7:0] LAST_IDX = 8'(CFG_BYTES - 1);

  scl_main_t s, n;
  logic [7:0] lk_byte;
  logic lk_ack, lk_first;
  logic tick, adv, rx, scl_s, sda_s, ack_s;
  logic start, stop, scl_rise, scl_fall;

  // receiver on the link clock; its byte is stable whenever its ack flag stands
  scl_link u_link (
    .link_clk_i(serial_clock_line_i),
    .nrst_i(nrst_i),
    .link_clr_i(s.clr),
    .sda_i(sda_i),
    .byte_o(lk_byte),
    .ack_o(lk_ack),
    .first_o(lk_first)
  );

  // next state: power-up capture, eeprom master engine, slave answer
  always_comb
  begin
    n = s;
    n.wr = 1'b0;
    n.clr = 1'b0;
    n.sy_sda = {s.sy_sda[0], sda_i};
    n.sy_scl = {s.sy_scl[0], serial_clock_line_i};
    n.sy_req = {s.sy_req[0], load_req_n_i};
    n.sy_mode = {s.sy_mode[0], config_mode_select_i};
    n.sy_ack = {s.sy_ack[0], lk_ack};
    n.sy_strap = {s.sy_strap[0], addr_strap_i};
    scl_s = s.sy_scl[1];
    sda_s = s.sy_sda[1];
    ack_s = s.sy_ack[1];
    n.sda_p = sda_s;
    n.scl_p = scl_s;
    n.ack_p = ack_s;
    n.lock = chan_locked_i;
    tick = (s.qc == QTR_LAST);
    n.qc = tick ? 8'h00 : s.qc + 8'h01;
    // hold the high quarter while a slave stretches the clock
    adv = tick & ~(s.q == 2'h2 & ~scl_s);
    rx = (s.ph == 2'h3);
    start = scl_s & s.scl_p & s.sda_p & ~sda_s;
    stop = scl_s & s.scl_p & ~s.sda_p & sda_s;
    scl_rise = scl_s & ~s.scl_p;
    scl_fall = ~scl_s & s.scl_p;
    if (s.wr)
      n.ptr = s.ptr + 8'h01;
    if (adv)
      n.q = s.q + 2'h1;
    unique case (s.st)
      ST_POR:
      begin
        n.por = s.por + 2'h1;
        if (s.por == `SCL_POR_WAIT)
        begin
          // wait for the synchronisers to fill, then latch straps once
          n.mode_sl = s.sy_mode[1];
          n.addr = `SCL_ADDR7_BASE + {3'h0, s.sy_strap[1]};
          if (s.sy_mode[1] & s.sy_req[1])
            n.addr = `SCL_ADDR7_BASE + {3'h0, `SCL_TEST_STRAP};
          n.lock_oe_n = 4'h0;
          n.st = s.sy_mode[1] ? ST_SLAVE : ST_WAIT_REQ;
        end
      end
      ST_WAIT_REQ:
        if (!s.sy_req[1])
        begin
          // bus untouched until the request pin is low
          n.st = ST_M_START;
          n.q = 2'h0;
          n.qc = 8'h00;
          n.ph = 2'h0;
          n.sh = `SCL_EE_WR;
          n.ptr = 8'h00;
        end
      ST_M_START:
        if (adv)
          unique case (s.q)
            2'h0: n.sda_oe_n = 1'b1;
            2'h1: n.scl_oe_n = 1'b1;
            2'h2: n.sda_oe_n = 1'b0;
            2'h3:
            begin
              n.scl_oe_n = 1'b0;
              n.st = ST_M_BIT;
              n.bitn = 4'h0;
            end
          endcase
      ST_M_BIT:
        if (adv)
          unique case (s.q)
            // pins only pulled low or released
            2'h0: n.sda_oe_n = (s.bitn == 4'h8) ? ~(rx & (s.ptr != LAST_IDX))
                                               : (rx | s.sh[7]);
            2'h1: n.scl_oe_n = 1'b1;
            2'h2:
              if (rx && s.bitn != 4'h8)
                n.sh = {s.sh[6:0], sda_s};
            2'h3:
            begin
              n.scl_oe_n = 1'b0;
              if (s.bitn != 4'h8)
              begin
                n.bitn = s.bitn + 4'h1;
                if (!rx)
                  n.sh = {s.sh[6:0], 1'b0};
              end
              else
              begin
                n.bitn = 4'h0;
                unique case (s.ph)
                  2'h0:
                  begin
                    n.ph = 2'h1;
                    n.sh = `SCL_EE_WORD;
                  end
                  2'h1:
                  begin
                    n.ph = 2'h2;
                    n.sh = `SCL_EE_RD;
                    n.st = ST_M_START;
                  end
                  2'h2: n.ph = 2'h3;
                  2'h3:
                  begin
                    // each fetched byte lands at the next register index
                    n.wr = 1'b1;
                    n.wd = s.sh;
                    if (s.ptr == LAST_IDX)
                      n.st = ST_M_STOP;
                  end
                endcase
              end
            end
          endcase
      ST_M_STOP:
        if (adv)
          unique case (s.q)
            2'h0: n.sda_oe_n = 1'b0;
            2'h1: n.scl_oe_n = 1'b1;
            2'h2: n.sda_oe_n = 1'b1;
            2'h3:
            begin
              n.st = ST_SLAVE;
              n.done_n = 1'b0;
            end
          endcase
      ST_SLAVE:
      begin
        n.scl_oe_n = 1'b1;
        if (start | stop)
        begin
          n.clr = start;
          n.matched = 1'b0;
          n.rd_on = 1'b0;
          n.want = 1'b0;
        end
        else if (ack_s & ~s.ack_p & ~s.rd_on)
        begin
          if (lk_first)
          begin
            n.matched = (lk_byte[7:1] == s.addr);
            n.rnw = lk_byte[0];
            n.want = (lk_byte[7:1] == s.addr);
            n.pend = 1'b1;
          end
          else if (s.matched & ~s.rnw)
          begin
            n.want = 1'b1;
            n.pend = 1'b0;
            if (s.pend)
              n.ptr = lk_byte;
            else
            begin
              n.wr = 1'b1;
              n.wd = lk_byte;
            end
          end
        end
        else if (~ack_s & s.ack_p & ~s.rd_on)
        begin
          n.want = 1'b0;
          if (s.matched & s.rnw)
          begin
            n.rd_on = 1'b1;
            n.sh = reg_rdata_i;
            n.rbit = 4'h8; // reload, then msb on the fall that ends the acknowledge
            n.want = ~reg_rdata_i[7];
          end
        end
        else if (s.rd_on & scl_rise & (s.rbit == 4'h8))
        begin
          // host acknowledge moves to the next register, a nack ends the read
          if (sda_s)
            {n.rd_on, n.matched} = 2'b00; // a late ack edge must not restart the read
          else
            n.ptr = s.ptr + 8'h01;
        end
        else if (s.rd_on & scl_fall)
        begin
          n.rbit = s.rbit + 4'h1;
          n.want = 1'b0;
          if (s.rbit < 4'h7)
          begin
            n.sh = {s.sh[6:0], 1'b0};
            n.want = ~s.sh[6];
          end
          else if (s.rbit == 4'h8)
          begin
            n.sh = reg_rdata_i;
            n.rbit = 4'h0;
            n.want = ~reg_rdata_i[7];
          end
        end
        // data only changes while the clock is low, else it reads as start or stop
        if (!scl_s)
          n.sda_oe_n = ~n.want;
      end
    endcase
  end

  // single register of all core-clock state; the receiver keeps its own
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s <= '0;
      s.st <= ST_POR;
      s.done_n <= 1'b1;
      s.lock_oe_n <= 4'hf;
      s.sda_oe_n <= 1'b1;
      s.scl_oe_n <= 1'b1;
    end
    else
      s <= n;
  end

  // pins driven only low
  assign sda_o = 1'b0;
  assign serial_clock_line_o = 1'b0;
  assign sda_oe_n_o = s.sda_oe_n;
  assign serial_clock_line_oe_n_o = s.scl_oe_n;
  assign load_done_n_o = s.done_n;
  assign lock_o = s.lock;
  assign lock_oe_n_o = s.lock_oe_n;
  assign reg_wr_o = s.wr;
  assign reg_addr_o = s.ptr;
  assign reg_wdata_o = s.wd;

  sequence stop_end_s;
    s.st == ST_M_STOP && adv && s.q == 2'h3;
  endsequence

  done_stay_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !load_done_n_o |=> !load_done_n_o)
    else $error("load done went back high");
  done_timing_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    stop_end_s |=> !load_done_n_o && s.st == ST_SLAVE && serial_clock_line_oe_n_o)
    else $error("fetch end not followed by done and slave mode");
  idle_bus_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (s.st == ST_WAIT_REQ || s.st == ST_POR) |-> sda_oe_n_o && serial_clock_line_oe_n_o)
    else $error("bus driven before load request");
  fetch_go_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (s.st == ST_WAIT_REQ && !s.sy_req[1]) |=> s.st == ST_M_START)
    else $error("fetch did not start on request");
  slave_nofetch_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (s.st != ST_POR && s.mode_sl) |-> s.st == ST_SLAVE && load_done_n_o)
    else $error("slave mode left slave state");
  addr_map_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (s.st == ST_POR && s.por == `SCL_POR_WAIT && !(s.sy_mode[1] && s.sy_req[1]))
    |=> {s.addr, 1'b0} == 8'h30 + {3'h0, $past(s.sy_strap[1]), 1'b0})
    else $error("address not formed from strap");
  strap_in_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s.st == ST_POR |-> lock_oe_n_o == 4'hf)
    else $error("strap pins driven during capture");
  lock_pin_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (lock_oe_n_o == 4'h0) ##1 (lock_oe_n_o == 4'h0) |-> lock_o == $past(chan_locked_i))
    else $error("lock pin does not follow channel lock");
  sda_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (s.st == ST_SLAVE && $past(s.st) == ST_SLAVE && $changed(sda_oe_n_o)) |-> !$past(scl_s))
    else $error("data changed while clock high");
endmodule // scl_loader
`default_nettype wire

// [core/scl_pkg.sv]
// types of the smbus configuration loader
`default_nettype none
package scl_pkg;
  typedef enum logic [2:0] {ST_POR, ST_WAIT_REQ, ST_M_START, ST_M_BIT, ST_M_STOP, ST_SLAVE}
    scl_state_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic [7:0] sh;
    logic first;
    logic ack;
  } scl_link_t;

  typedef struct packed {
    scl_state_t st;
    logic [1:0] por;
    logic mode_sl;
    logic [6:0] addr;
    logic done_n;
    logic [3:0] lock_oe_n;
    logic [3:0] lock;
    logic [7:0] qc;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [1:0] ph;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic sda_oe_n;
    logic scl_oe_n;
    logic [1:0] sy_sda;
    logic [1:0] sy_scl;
    logic [1:0] sy_req;
    logic [1:0] sy_mode;
    logic [1:0] sy_ack;
    logic [1:0][3:0] sy_strap;
    logic sda_p;
    logic scl_p;
    logic ack_p;
    logic clr;
    logic matched;
    logic rnw;
    logic pend;
    logic rd_on;
    logic [3:0] rbit;
    logic want;
    logic wr;
    logic [7:0] wd;
  } scl_main_t;
endpackage
`default_nettype wire

// [sim/scl_ee_model.sv]
// behavioural serial eeprom standing on the far side of the loader
`default_nettype none
module scl_ee_model (
  // resolved bus wires and the stretch enable
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic stretch_i,
  // open drain outputs, 0 pulls the wire low
  output logic sda_o,
  output logic scl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic act = 1'b0;
  logic rd = 1'b0;
  logic mine = 1'b0;
  logic first = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] ptr = 8'h00;
  logic [7:0] dat;
  int bitc = 0;
  initial sda_o = 1'b1;
  initial scl_o = 1'b1;
  // stored image, byte k holds k*37+5
  assign dat = ptr * 8'h25 + 8'h05;
  // start and repeated start: data falls while the clock is high
  always @(negedge sda_i)
    if (scl_i)
    begin
      act = 1'b1;
      first = 1'b1;
      bitc = 0;
      rd = 1'b0;
      ptr = 8'h00;
    end
  // stop ends any transfer and releases the line
  always @(posedge sda_i)
    if (scl_i)
    begin
      act = 1'b0;
      sda_o = 1'b1;
    end
  // shift on the rising clock; the 9th rise carries the ack slot
  always @(posedge scl_i)
    if (act)
    begin
      if (bitc < 8)
        sh = {sh[6:0], sda_i};
      else if (rd && sda_i)
        act = 1'b0; // master nack ends the read
      else if (rd)
        ptr = ptr + 8'h01;
      else
      begin
        rd = mine && sh[0];
        first = 1'b0;
      end
      if (bitc == 7 && first)
        mine = (sh[7:1] == 7'h50);
      bitc = (bitc == 8) ? 0 : bitc + 1;
    end
  // data changes only while the clock is low; released unless pulling low
  always @(negedge scl_i)
    if (!act || !mine)
      sda_o = 1'b1;
    else if (bitc == 8)
      sda_o = rd;
    else if (rd)
      sda_o = dat[7 - bitc];
    else
      sda_o = 1'b1;
  // slow answer: stretch each low clock phase so the master has to wait
  always @(negedge scl_i)
    if (stretch_i && act && mine)
    begin
      scl_o = 1'b0;
      #9000;
      scl_o = 1'b1;
    end
endmodule // scl_ee_model
`default_nettype wire

// [sim/scl_loader_tb.sv]
// self-checking bench of the smbus configuration loader
`default_nettype none
module scl_loader_tb;
  import scl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CFGB = 4;
  localparam int HT = 30;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic mode = 1'b0;
  logic req_n = 1'b1;
  logic [3:0] strap = 4'h0;
  logic [3:0] locked = 4'h0;
  logic host_scl = 1'b1;
  logic host_sda = 1'b1;
  logic stretch = 1'b0;
  logic sda_o, sda_oe_n, scl_o, scl_oe_n, done_n, reg_wr, ee_sda, ee_scl, ack;
  logic [3:0] lock, lock_oe_n;
  logic [7:0] reg_addr, reg_wdata;
  wire logic scl_w, sda_w;
  wire logic [3:0] pin;
  wire logic [7:0] rdata;
  int n_mismatch = 0;
  int checks_done = 0;
  int nw = 0;
  logic scl_low_seen = 1'b0;
  logic [7:0] wa [0:31];
  logic [7:0] wd [0:31];
  always #25 clk = ~clk;
  // wired-and bus, pulled high when nobody drives; shared strap pins read the strap value unless the loader drives them
  assign scl_w = (scl_oe_n | scl_o) & host_scl & ee_scl;
  assign sda_w = (sda_oe_n | sda_o) & host_sda & ee_sda;
  assign pin = (lock_oe_n & strap) | (~lock_oe_n & lock);
  assign rdata = reg_addr ^ 8'ha5;
  scl_loader #(.CFG_BYTES(CFGB)) u_scl_loader (.clk_i(clk), .nrst_i(nrst),
    .serial_clock_line_i(scl_w), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
    .serial_clock_line_o(scl_o), .serial_clock_line_oe_n_o(scl_oe_n),
    .config_mode_select_i(mode), .load_req_n_i(req_n), .load_done_n_o(done_n),
    .addr_strap_i(pin), .lock_o(lock), .lock_oe_n_o(lock_oe_n), .chan_locked_i(locked),
    .reg_wr_o(reg_wr), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_rdata_i(rdata));
  scl_ee_model u_scl_ee_model (.scl_i(scl_w), .sda_i(sda_w), .stretch_i(stretch),
    .sda_o(ee_sda), .scl_o(ee_scl));
  // log register writes and any pull on the clock line by the loader
  always @(posedge clk)
  begin
    if (reg_wr && nw < 32)
    begin
      wa[nw] = reg_addr;
      wd[nw] = reg_wdata;
      nw = nw + 1;
    end
    if (!scl_oe_n)
      scl_low_seen = 1'b1;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic hw(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic boot(input logic m, input logic r, input logic [3:0] s);
    nrst <= 1'b0;
    mode <= m;
    req_n <= r;
    strap <= s;
    hw(6);
    nrst <= 1'b1;
    hw(12);
    nw = 0;
    scl_low_seen = 1'b0;
  endtask
  // host side: one bit is data set, clock high, sample, clock low
  task automatic h_bit(input logic b, output logic s);
    host_sda <= b;
    hw(HT);
    host_scl <= 1'b1;
    hw(HT);
    s = sda_w;
    host_scl <= 1'b0;
    hw(HT);
  endtask
  task automatic h_byte(input logic [7:0] b, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) h_bit(b[i], s);
    h_bit(1'b1, s);
    a = ~s;
  endtask
  task automatic h_start;
    host_sda <= 1'b1;
    host_scl <= 1'b1;
    hw(HT);
    host_sda <= 1'b0;
    hw(HT);
    host_scl <= 1'b0;
    hw(HT);
  endtask
  task automatic h_stop;
    host_sda <= 1'b0;
    hw(HT);
    host_scl <= 1'b1;
    hw(HT);
    host_sda <= 1'b1;
    hw(HT);
  endtask
  task automatic h_wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d,
                      output logic ak);
    logic x;
    h_start;
    h_byte(a, ak);
    if (ak)
    begin
      h_byte(p, x);
      h_byte(d, x);
    end
    h_stop;
  endtask
  // two bytes: host acknowledges the first, refuses the second
  task automatic h_rd(input logic [7:0] a, output logic ak, output logic [7:0] d,
                      output logic [7:0] d2);
    logic x;
    h_start;
    h_byte(a, ak);
    for (int i = 7; i >= 0; i--) h_bit(1'b1, d[i]);
    h_bit(1'b0, x);
    for (int i = 7; i >= 0; i--) h_bit(1'b1, d2[i]);
    h_bit(1'b1, x);
    h_stop;
  endtask
  // master mode: wait for request, fetch with a slow eeprom, then act as slave
  task automatic t_master;
    int k;
    boot(1'b0, 1'b1, 4'h5);
    stretch <= 1'b1;
    locked <= 4'ha;
    hw(300);
    chk("lock", lock, 4'ha);
    chk("lock oe", lock_oe_n, 4'h0);
    chk("early bus", scl_low_seen, 1'b0);
    chk("early done", done_n, 1'b1);
    strap <= 4'h0;
    req_n <= 1'b0;
    k = 0;
    while (done_n !== 1'b0 && k < 60000)
    begin
      hw(1);
      k++;
    end
    if (k == 60000)
    begin
      n_mismatch++;
      stop_test;
    end
    chk("fetch count", 8'(nw), 8'(CFGB));
    for (k = 0; k < CFGB; k++)
    begin
      chk("fetch addr", wa[k], 8'(k));
      chk("fetch data", wd[k], 8'(k * 37 + 5));
    end
    hw(50);
    chk("sda free", sda_oe_n, 1'b1);
    chk("scl free", scl_oe_n, 1'b1);
    stretch <= 1'b0;
    nw = 0;
    h_wr(8'h3a, 8'h07, 8'hc3, ack);
    chk("ack", ack, 1'b1);
    chk("wr addr", wa[0], 8'h07);
    chk("wr data", wd[0], 8'hc3);
    chk("done kept", done_n, 1'b0);
  endtask
  // slave mode with request tied low: strap address, write, read the next two registers
  task automatic t_slave;
    logic [7:0] d, d2;
    boot(1'b1, 1'b0, 4'hf);
    h_wr(8'h4e, 8'h20, 8'h99, ack);
    chk("ack", ack, 1'b1);
    chk("wr count", 8'(nw), 8'h01);
    chk("wr addr", wa[0], 8'h20);
    chk("wr data", wd[0], 8'h99);
    h_rd(8'h4f, ack, d, d2);
    chk("rd ack", ack, 1'b1);
    chk("rd data", d, 8'h84);
    chk("rd data2", d2, 8'h87);
    nw = 0;
    h_wr(8'h30, 8'h01, 8'h02, ack);
    chk("foreign ack", ack, 1'b0);
    chk("foreign wr", 8'(nw), 8'h00);
    chk("no fetch", scl_low_seen, 1'b0);
    chk("done high", done_n, 1'b1);
  endtask
  // slave mode with request high: straps ignored, fixed address
  task automatic t_test;
    boot(1'b1, 1'b1, 4'h9);
    h_wr(8'h42, 8'h01, 8'h02, ack);
    chk("strap ack", ack, 1'b0);
    h_wr(8'h30, 8'h05, 8'h5a, ack);
    chk("test ack", ack, 1'b1);
    chk("wr addr", wa[0], 8'h05);
    chk("wr data", wd[0], 8'h5a);
    req_n <= 1'b0;
    hw(300);
    chk("no fetch", scl_low_seen, 1'b0);
    chk("done high", done_n, 1'b1);
  endtask
  initial
  begin
    t_master;
    t_slave;
    t_test;
    stop_test;
  end
endmodule // scl_loader_tb
`default_nettype wire
